// *** include/tms_pkg.sv ***
`default_nettype none

package tms_pkg;

  // ----------------------------------------------------------------
  // Pin sampling vector
  // ----------------------------------------------------------------
  localparam int unsigned PIN_W      = 11;
  localparam int unsigned PIN_SCLK   = 0;
  localparam int unsigned PIN_CS_N   = 1;
  localparam int unsigned PIN_SDI    = 2;
  localparam int unsigned PIN_TRX_H  = 3;
  localparam int unsigned PIN_TRX_V  = 4;
  localparam int unsigned PIN_LOAD_H = 5;
  localparam int unsigned PIN_LOAD_V = 6;
  localparam int unsigned PIN_SEL_LO = 7;
  // Chip select idles high, all others low
  localparam logic [PIN_W-1:0] PIN_RST = 11'h002;

  // ----------------------------------------------------------------
  // Serial frame: read flag, chip address, register index, data
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W     = 4;
  localparam int unsigned IDX_W      = 3;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned HDR_BITS   = 8;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned HDR_RD_POS = 7;
  localparam int unsigned HDR_AD_LO  = 3;
  localparam int unsigned HDR_IX_LO  = 0;
  localparam logic [CNT_W-1:0] CNT_HDR_LAST = 5'h07;
  localparam logic [CNT_W-1:0] CNT_FULL     = 5'h10;

  // ----------------------------------------------------------------
  // Polarity groups and load sequence
  // ----------------------------------------------------------------
  localparam int unsigned GRP_N     = 2;
  localparam int unsigned GRP_H     = 0;
  localparam int unsigned GRP_V     = 1;
  localparam int unsigned GRP_CFG_W = 32;
  localparam int unsigned LOAD_CNT_W = 2;
  localparam logic [LOAD_CNT_W-1:0] LOAD_LAST = 2'h2;
  localparam logic [GRP_CFG_W-1:0]  CFG_RST   = 32'h0000_0000;

  typedef enum logic [3:0] {
    TMS_IDLE = 4'h1,
    TMS_HDR  = 4'h2,
    TMS_DATA = 4'h4,
    TMS_SKIP = 4'h8
  } tms_state_t;

endpackage

`default_nettype wire

// *** logic/tms_top.sv ***
// How it works
// - Write data captured on serial clock rise
// - Read data changes on serial clock fall
// - Horizontal select rise enters transmit
// - Select fall returns group to receive
// - Vertical select drives vertical group only
// - Frames accepted only on chip address match
// - Third load rise commits staged group values
// - Chip select low enables; rise commits write
`timescale 1ns/1ns
`default_nettype none

module tms_top (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_rst_n,
  input  wire logic                           i_sclk,
  input  wire logic                           i_cs_n,
  input  wire logic                           i_sdi,
  input  wire logic                           i_device_select_bit0,
  input  wire logic                           i_device_select_bit1,
  input  wire logic                           i_device_select_bit2,
  input  wire logic                           i_device_select_bit3,
  input  wire logic                           i_horiz_txrx_select,
  input  wire logic                           i_vert_txrx_select,
  input  wire logic                           i_load_horiz,
  input  wire logic                           i_load_vert,
  output logic                                o_sdo,
  output logic                                o_sdo_oe,
  output logic                                o_horiz_tx_mode,
  output logic                                o_vert_tx_mode,
  output logic [tms_pkg::GRP_CFG_W-1:0]       o_horiz_cfg,
  output logic [tms_pkg::GRP_CFG_W-1:0]       o_vert_cfg
);
  import tms_pkg::*;

  function automatic logic rise_of(input logic cur, input logic prev);
    rise_of = cur & ~prev;
  endfunction

  function automatic logic fall_of(input logic cur, input logic prev);
    fall_of = ~cur & prev;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PIN_W-1:0]                   pin_raw;
  logic [PIN_W-1:0]                   meta_ff;
  logic [PIN_W-1:0]                   sync_ff;
  logic [PIN_W-1:0]                   prev_ff;

  assign pin_raw = {i_device_select_bit3, i_device_select_bit2, i_device_select_bit1,
                    i_device_select_bit0, i_load_vert, i_load_horiz, i_vert_txrx_select,
                    i_horiz_txrx_select, i_sdi, i_cs_n, i_sclk};

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      meta_ff <= PIN_RST;
      sync_ff <= PIN_RST;
      prev_ff <= PIN_RST;
    end else begin
      meta_ff <= pin_raw;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  logic                               sclk_rise;
  logic                               sclk_fall;
  logic                               cs_rise;
  logic                               cs_on;
  logic                               sdi_bit;
  logic [ADDR_W-1:0]                  chip_addr;

  assign sclk_rise = rise_of(sync_ff[PIN_SCLK], prev_ff[PIN_SCLK]);
  assign sclk_fall = fall_of(sync_ff[PIN_SCLK], prev_ff[PIN_SCLK]);
  assign cs_rise   = rise_of(sync_ff[PIN_CS_N], prev_ff[PIN_CS_N]);
  assign cs_on     = ~sync_ff[PIN_CS_N];
  assign sdi_bit   = sync_ff[PIN_SDI];
  assign chip_addr = sync_ff[PIN_SEL_LO +: ADDR_W];

  // ----------------------------------------------------------------
  // Serial frame receiver
  // ----------------------------------------------------------------
  tms_state_t                         state_ff;
  logic [CNT_W-1:0]                   bit_cnt_ff;
  logic [FRAME_BITS-1:0]              shift_ff;
  logic [HDR_BITS-1:0]                hdr_ff;
  logic [FRAME_BITS-1:0]              nxt_shift;
  logic                               addr_hit;

  assign nxt_shift = {shift_ff[FRAME_BITS-2:0], sdi_bit};
  assign addr_hit  = (nxt_shift[HDR_AD_LO +: ADDR_W] == chip_addr);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_ff <= TMS_IDLE;
    end else if (!cs_on) begin
      state_ff <= TMS_IDLE;
    end else begin
      case (state_ff)
        TMS_IDLE: begin
          state_ff <= TMS_HDR;
        end
        TMS_HDR: begin
          if (sclk_rise && bit_cnt_ff == CNT_HDR_LAST) begin
            state_ff <= addr_hit ? TMS_DATA : TMS_SKIP;
          end
        end
        TMS_DATA: begin
          state_ff <= TMS_DATA;
        end
        TMS_SKIP: begin
          state_ff <= TMS_SKIP;
        end
        default: begin
          state_ff <= TMS_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else if (state_ff == TMS_IDLE) begin
      bit_cnt_ff <= '0;
      shift_ff   <= '0;
    end else if (sclk_rise && bit_cnt_ff != CNT_FULL &&
                 (state_ff == TMS_HDR || state_ff == TMS_DATA)) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h01;
      shift_ff   <= nxt_shift;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      hdr_ff <= '0;
    end else if (state_ff == TMS_HDR && sclk_rise && bit_cnt_ff == CNT_HDR_LAST) begin
      hdr_ff <= nxt_shift[HDR_BITS-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Staged registers, written when chip select rises
  // ----------------------------------------------------------------
  logic [GRP_N-1:0][GRP_CFG_W-1:0]    stage_ff;
  logic [GRP_N-1:0][GRP_CFG_W-1:0]    act_ff;
  logic                               hdr_rd;
  logic [IDX_W-1:0]                   hdr_idx;
  logic                               wr_commit;

  assign hdr_rd    = hdr_ff[HDR_RD_POS];
  assign hdr_idx   = hdr_ff[HDR_IX_LO +: IDX_W];
  assign wr_commit = cs_rise && state_ff == TMS_DATA && bit_cnt_ff == CNT_FULL && !hdr_rd;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      stage_ff <= '0;
    end else if (wr_commit) begin
      stage_ff[hdr_idx[IDX_W-1]][hdr_idx[1:0]*DATA_W +: DATA_W] <= shift_ff[DATA_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Read data out, changing on serial clock fall
  // ----------------------------------------------------------------
  logic [DATA_W-1:0]                  rd_shift_ff;
  logic                               sdo_ff;
  logic                               sdo_oe_ff;
  logic                               rd_phase;

  assign rd_phase = state_ff == TMS_DATA && hdr_rd && cs_on;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rd_shift_ff <= '0;
      sdo_ff      <= 1'b0;
    end else if (state_ff == TMS_HDR && sclk_rise && bit_cnt_ff == CNT_HDR_LAST) begin
      rd_shift_ff <= stage_ff[nxt_shift[HDR_IX_LO+IDX_W-1]]
                             [nxt_shift[1:0]*DATA_W +: DATA_W];
    end else if (rd_phase && sclk_fall) begin
      sdo_ff      <= rd_shift_ff[DATA_W-1];
      rd_shift_ff <= {rd_shift_ff[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sdo_oe_ff <= 1'b0;
    end else if (!rd_phase) begin
      sdo_oe_ff <= 1'b0;
    end else if (sclk_fall) begin
      sdo_oe_ff <= 1'b1;
    end
  end

  assign o_sdo    = sdo_ff;
  assign o_sdo_oe = sdo_oe_ff;

  // ----------------------------------------------------------------
  // Per polarity group: transmit select and triple load
  // ----------------------------------------------------------------
  logic [GRP_N-1:0]                   tx_ff;
  logic [GRP_N-1:0][LOAD_CNT_W-1:0]   load_cnt_ff;
  logic [GRP_N-1:0]                   trx_cur;
  logic [GRP_N-1:0]                   trx_prev;
  logic [GRP_N-1:0]                   ld_cur;
  logic [GRP_N-1:0]                   ld_prev;

  assign trx_cur  = sync_ff[PIN_TRX_V:PIN_TRX_H];
  assign trx_prev = prev_ff[PIN_TRX_V:PIN_TRX_H];
  assign ld_cur   = sync_ff[PIN_LOAD_V:PIN_LOAD_H];
  assign ld_prev  = prev_ff[PIN_LOAD_V:PIN_LOAD_H];

  for (genvar g = 0; g < GRP_N; g++) begin : g_grp
    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        tx_ff[g] <= 1'b0;
      end else if (rise_of(trx_cur[g], trx_prev[g])) begin
        tx_ff[g] <= 1'b1;
      end else if (fall_of(trx_cur[g], trx_prev[g])) begin
        tx_ff[g] <= 1'b0;
      end
    end

    always_ff @(posedge i_clk_sys) begin
      if (!i_rst_n) begin
        load_cnt_ff[g] <= '0;
        act_ff[g]      <= CFG_RST;
      end else if (rise_of(ld_cur[g], ld_prev[g])) begin
        if (load_cnt_ff[g] == LOAD_LAST) begin
          load_cnt_ff[g] <= '0;
          act_ff[g]      <= stage_ff[g];
        end else begin
          load_cnt_ff[g] <= load_cnt_ff[g] + 2'h1;
        end
      end
    end

    a_tx_rise_enter: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rise_of(trx_cur[g], trx_prev[g]) |=> tx_ff[g])
      else $error("tx mode not entered on select rise");
    a_tx_fall_exit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      fall_of(trx_cur[g], trx_prev[g]) |=> !tx_ff[g])
      else $error("rx mode not entered on select fall");
    a_tx_level_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      trx_cur[g] == trx_prev[g] |=> $stable(tx_ff[g]))
      else $error("tx mode moved without select edge");
    a_load_third_commit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      rise_of(ld_cur[g], ld_prev[g]) && load_cnt_ff[g] == LOAD_LAST
      |=> act_ff[g] == $past(stage_ff[g]) && load_cnt_ff[g] == 2'h0)
      else $error("third load rise did not commit");
    a_load_early_hold: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
      load_cnt_ff[g] != LOAD_LAST |=> $stable(act_ff[g]))
      else $error("active values changed before third load");
  end

  assign o_horiz_tx_mode = tx_ff[GRP_H];
  assign o_vert_tx_mode  = tx_ff[GRP_V];
  assign o_horiz_cfg     = act_ff[GRP_H];
  assign o_vert_cfg      = act_ff[GRP_V];

  // ----------------------------------------------------------------
  // Serial checks and coverage
  // ----------------------------------------------------------------
  a_spi_rise_capture: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_ff == TMS_HDR && sclk_rise && cs_on |=> shift_ff[0] == $past(sdi_bit))
    else $error("input bit not captured on clock rise");
  a_sdo_fall_only: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !$past(sclk_fall) |-> $stable(o_sdo))
    else $error("output bit changed away from clock fall");
  a_addr_miss_skip: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_ff == TMS_HDR && cs_on && sclk_rise && bit_cnt_ff == CNT_HDR_LAST && !addr_hit
    |=> state_ff == TMS_SKIP ##1 !wr_commit)
    else $error("frame for other chip address not skipped");
  a_cs_high_idle: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !cs_on |=> state_ff == TMS_IDLE && !o_sdo_oe)
    else $error("serial logic active with chip select high");
  a_cs_rise_commit: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    wr_commit |=> stage_ff[$past(hdr_idx[IDX_W-1])][$past(hdr_idx[1:0])*DATA_W +: DATA_W]
                  == $past(shift_ff[DATA_W-1:0]))
    else $error("write not committed on chip select rise");

  c_write_frame: cover property (@(posedge i_clk_sys) wr_commit);
  c_read_frame: cover property (@(posedge i_clk_sys) rd_phase && sclk_fall);
  c_tx_enter: cover property (@(posedge i_clk_sys) tx_ff[GRP_H] && tx_ff[GRP_V]);
  c_load_commit: cover property (@(posedge i_clk_sys)
    rise_of(ld_cur[GRP_V], ld_prev[GRP_V]) && load_cnt_ff[GRP_V] == LOAD_LAST);

endmodule

`default_nettype wire

// *** bench/tms_host.sv ***
`timescale 1ns/1ns
`default_nettype none

module tms_host (
  input  wire logic i_clk,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe,
  output logic      o_sclk,
  output logic      o_cs_n,
  output logic      o_sdi,
  output logic      o_trx_h,
  output logic      o_trx_v,
  output logic      o_load_h,
  output logic      o_load_v
);
  // ----------------------------------------------------------------
  // Idle pins; selects low so both groups start in receive
  // ----------------------------------------------------------------
  initial begin
    o_sclk   = 1'b0;
    o_cs_n   = 1'b1;
    o_sdi    = 1'b0;
    o_trx_h  = 1'b0;
    o_trx_v  = 1'b0;
    o_load_h = 1'b0;
    o_load_v = 1'b0;
  end

  task automatic ticks(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // ----------------------------------------------------------------
  // One 16-bit frame, link clock 4 clk low and 4 clk high
  // ----------------------------------------------------------------
  task automatic frame(input logic rd, input logic [3:0] adr, input logic [2:0] idx,
                       input logic [7:0] wdat, output logic [7:0] rdat, output logic oe_any);
    logic [15:0] word;
    word   = {rd, adr, idx, wdat};
    rdat   = 8'h00;
    oe_any = 1'b0;
    o_cs_n <= 1'b0;
    ticks(4);
    for (int i = 15; i >= 0; i--) begin
      o_sdi <= word[i];
      ticks(4);
      o_sclk <= 1'b1;
      ticks(1);
      if (i < 8) begin
        // Released line shows the inverse of the last value
        rdat[i] = i_sdo_oe ? i_sdo : ~i_sdo;
        oe_any  = oe_any | i_sdo_oe;
      end
      ticks(3);
      o_sclk <= 1'b0;
    end
    ticks(4);
    o_cs_n <= 1'b1;
    o_sdi  <= ~word[0];
    ticks(8);
  endtask

  task automatic load(input logic vert, input int n);
    repeat (n) begin
      if (vert) o_load_v <= 1'b1; else o_load_h <= 1'b1;
      ticks(4);
      o_load_v <= 1'b0;
      o_load_h <= 1'b0;
      ticks(4);
    end
  endtask

  task automatic set_trx(input logic vert, input logic lvl);
    if (vert) o_trx_v <= lvl; else o_trx_h <= lvl;
  endtask
endmodule

`default_nettype wire

// *** bench/tms_top_tb.sv ***
`timescale 1ns/1ns
`default_nettype none

module tms_top_tb;
  import tms_pkg::*;
  localparam logic [3:0] ADDR = 4'h5;
  logic        clk, rst_n, sclk, cs_n, sdi, trx_h, trx_v, ld_h, ld_v;
  logic        sdo, sdo_oe, htx, vtx;
  logic [3:0]  dev_sel;
  logic [31:0] hcfg, vcfg;
  int          n_mismatch;
  int          tests_run;

  initial clk = 1'b0;
  always #10 clk = ~clk;

  tms_top dut (
    .i_clk_sys(clk), .i_rst_n(rst_n), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_device_select_bit0(dev_sel[0]), .i_device_select_bit1(dev_sel[1]),
    .i_device_select_bit2(dev_sel[2]), .i_device_select_bit3(dev_sel[3]),
    .i_horiz_txrx_select(trx_h), .i_vert_txrx_select(trx_v),
    .i_load_horiz(ld_h), .i_load_vert(ld_v), .o_sdo(sdo), .o_sdo_oe(sdo_oe),
    .o_horiz_tx_mode(htx), .o_vert_tx_mode(vtx), .o_horiz_cfg(hcfg), .o_vert_cfg(vcfg)
  );

  tms_host host (
    .i_clk(clk), .i_sdo(sdo), .i_sdo_oe(sdo_oe), .o_sclk(sclk), .o_cs_n(cs_n),
    .o_sdi(sdi), .o_trx_h(trx_h), .o_trx_v(trx_v), .o_load_h(ld_h), .o_load_v(ld_v)
  );

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %b exp %b", $time, what, got, exp);
    end
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic modes(input logic eh, input logic ev);
    host.ticks(6);
    chk_bit(htx, eh, "horiz mode");
    chk_bit(vtx, ev, "vert mode");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    modes(1'b0, 1'b0);
    chk_bit(sdo_oe, 1'b0, "oe after reset");
    chk_word(hcfg | vcfg, 32'h0000_0000, "cfg after reset");
    $display("test reset done");
  endtask

  task automatic t_trx;
    host.set_trx(1'b0, 1'b1);
    modes(1'b1, 1'b0);
    host.set_trx(1'b1, 1'b1);
    modes(1'b1, 1'b1);
    host.set_trx(1'b0, 1'b0);
    modes(1'b0, 1'b1);
    host.ticks(30);
    modes(1'b0, 1'b1);
    host.set_trx(1'b1, 1'b0);
    modes(1'b0, 1'b0);
    $display("test select edges done");
  endtask

  task automatic t_load;
    logic [7:0] rd;
    logic       oe;
    logic [7:0] pat [4] = '{8'h3c, 8'hc3, 8'h81, 8'h7e};
    for (int k = 0; k < 4; k++) host.frame(1'b0, ADDR, 3'(k), pat[k], rd, oe);
    host.frame(1'b0, ADDR, 3'h5, 8'h96, rd, oe);
    host.load(1'b0, 2);
    host.ticks(8);
    chk_word(hcfg, 32'h0000_0000, "cfg after two loads");
    host.load(1'b0, 1);
    host.ticks(8);
    chk_word(hcfg, 32'h7e81_c33c, "horiz cfg loaded");
    chk_word(vcfg, 32'h0000_0000, "vert cfg untouched");
    host.load(1'b1, 3);
    host.ticks(8);
    chk_word(vcfg, 32'h0000_9600, "vert cfg loaded");
    $display("test write and load done");
  endtask

  task automatic t_foreign;
    logic [7:0] rd;
    logic       oe;
    host.frame(1'b0, ADDR ^ 4'h8, 3'h0, 8'hff, rd, oe);
    host.frame(1'b1, ADDR ^ 4'h1, 3'h1, 8'h00, rd, oe);
    chk_bit(oe, 1'b0, "oe on foreign read");
    host.load(1'b0, 3);
    host.ticks(8);
    chk_word(hcfg, 32'h7e81_c33c, "foreign write ignored");
    $display("test address filter done");
  endtask

  task automatic t_read;
    logic [7:0] rd;
    logic       oe;
    host.frame(1'b1, ADDR, 3'h1, 8'h00, rd, oe);
    chk_bit(oe, 1'b1, "oe on read");
    chk_word({24'h0, rd}, 32'h0000_00c3, "horiz read data");
    host.frame(1'b1, ADDR, 3'h5, 8'h00, rd, oe);
    chk_word({24'h0, rd}, 32'h0000_0096, "vert read data");
    $display("test read back done");
  endtask

  task automatic t_addr;
    logic [7:0] rd;
    logic       oe;
    dev_sel <= 4'ha;
    host.ticks(4);
    host.frame(1'b1, 4'ha, 3'h1, 8'h00, rd, oe);
    chk_bit(oe, 1'b1, "oe at new address");
    chk_word({24'h0, rd}, 32'h0000_00c3, "read at new address");
    host.frame(1'b1, ADDR, 3'h1, 8'h00, rd, oe);
    chk_bit(oe, 1'b0, "oe at old address");
    host.frame(1'b0, 4'ha, 3'h6, 8'h5a, rd, oe);
    host.load(1'b1, 3);
    host.ticks(8);
    chk_word(vcfg, 32'h005a_9600, "write at new address");
    dev_sel <= ADDR;
    host.ticks(4);
    $display("test address change done");
  endtask

  initial begin
    n_mismatch = 0;
    tests_run  = 0;
    rst_n      = 1'b0;
    dev_sel    = ADDR;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    host.ticks(4);
    t_reset();
    t_trx();
    t_load();
    t_foreign();
    t_read();
    t_addr();
    give_verdict();
  end

  initial begin
    #2000000;
    n_mismatch++;
    $display("Error %0t: run did not finish", $time);
    give_verdict();
  end
endmodule

`default_nettype wire
